// File: core/scs_pkg.sv
// Constants, codes and timing counts shared by the six channel switch core.
// Assumes a 200 MHz ref_clk and a serial master that owns the serial clock.

package scs_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int NCH              = 6;        // Number of channels.
  localparam int REF_CLK_MHZ      = 200;      // Core clock rate.
  localparam int SCLK_MAX_MHZ     = 5;        // Highest serial rate.
  localparam int CS_GAP_NS        = 150;      // Least gap between frames.
  localparam int CS_GAP_DIAG_US   = 200;      // Gap for fresh diagnosis.
  localparam int FAULT_FILTER_US  = 120;      // Fault filter time.
  localparam int FAULT_FILTER_CYC = FAULT_FILTER_US * REF_CLK_MHZ;
  localparam int THERM_PERIOD_US  = 100;      // Thermal chop period.
  localparam int THERM_PERIOD_CYC = THERM_PERIOD_US * REF_CLK_MHZ;
  localparam int THERM_ON_US      = 5;        // On part of the chop.
  localparam int THERM_ON_CYC     = THERM_ON_US * REF_CLK_MHZ;
  localparam int FILT_W           = 15;       // Filter counter width.
  localparam int THERM_W          = 15;       // Chop counter width.

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int         FRAME_BITS = 16;     // Clocks in a good frame.
  localparam int         CNT_W      = 5;      // Clock counter width.
  localparam int         CMD_MSB    = 15;     // Instruction field top.
  localparam int         CMD_LSB    = 10;     // Instruction field bottom.
  localparam int         DATA_MSB   = 7;      // Channel bits top.
  localparam int         DATA_LSB   = 2;      // Channel bits bottom.
  localparam logic [1:0] ADDR_TAG   = 2'h2;   // Bits 7 and 6 of instruction.
  localparam logic [1:0] READ_PAD   = 2'h3;   // Two high bits on readback.

  // Instruction codes, bits 7 down to 2 of the instruction byte.
  localparam logic [5:0] CMD_WR_SCON = 6'h26;
  localparam logic [5:0] CMD_RD_SCON = 6'h25;
  localparam logic [5:0] CMD_WR_MUX  = 6'h2a;
  localparam logic [5:0] CMD_RD_MUX  = 6'h29;
  localparam logic [5:0] CMD_READ_DIAGNOSIS_COMMAND = 6'h20;

  // Reset values of the serial control and select registers.
  localparam logic [NCH-1:0] SCON_RST = 6'h00;
  localparam logic [NCH-1:0] MUX_RST  = 6'h00;

  // Per channel fault code.
  typedef enum logic [1:0] {
    SCS_CODE_GND  = 2'b00,
    SCS_CODE_OVL  = 2'b01,
    SCS_CODE_OPEN = 2'b10,
    SCS_CODE_OK   = 2'b11
  } scs_code_t;

endpackage

// File: core/scs_chan_if.sv
// Interface between the core top and one channel diagnosis slice.
// Assumes all members are on ref_clk and already synchronised.
`timescale 1ns/10ps
interface scs_chan_if;
  import scs_pkg::*;
  logic      demand;     // Channel asked on by the control path.
  logic      duty;       // Thermal chop window.
  logic      on_state;   // Present registered output state.
  logic      battery;    // Battery short or overload sense.
  logic      ground;     // Ground short sense.
  logic      open_load;  // Open load sense.
  logic      temp;       // Channel temperature sensor above threshold.
  logic      clear;      // Diagnosis read clears the code.
  logic      drive;      // Next output state.
  logic      hot;        // Heat seen while on.
  scs_code_t code;       // Stored fault code.
  modport top  (output demand, duty, on_state, battery, ground, open_load,
                temp, clear, input drive, hot, code);
  modport chan (input demand, duty, on_state, battery, ground, open_load,
                temp, clear, output drive, hot, code);
endinterface // scs_chan_if

// File: core/scs_chan_diag.sv
// One channel: fault filter, stored code and thermal chop.
// Assumes synchronised sense inputs and a one cycle clear pulse.
`timescale 1ns/10ps
module scs_chan_diag import scs_pkg::*; #(
  parameter int FILTER_CYCLES = FAULT_FILTER_CYC
) (
  input wire logic  ref_clk,
  input wire logic  rst_b,
  scs_chan_if.chan  ch
);

  scs_code_t         cand;     // Fault seen this cycle.
  scs_code_t         cand_q;   // Fault being timed.
  scs_code_t         code;     // Stored code.
  logic [FILT_W-1:0] cnt;      // Persistence counter.
  logic              fire;     // Fault has lasted the filter time.

  // Pick the fault that may be judged in the present switch state.
  always_comb begin
    cand = SCS_CODE_OK;
    if (ch.on_state) begin
      if (ch.battery) begin
        cand = SCS_CODE_OVL;
      end
    end else if (ch.ground) begin
      cand = SCS_CODE_GND;
    end else if (ch.open_load) begin
      cand = SCS_CODE_OPEN;
    end
  end

  // Restart timing whenever the seen fault changes.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cand_q <= SCS_CODE_OK;
      cnt    <= '0;
    end else if (cand != cand_q) begin
      cand_q <= cand;
      cnt    <= '0;
    end else if (cand != SCS_CODE_OK && cnt != FILT_W'(FILTER_CYCLES - 1)) begin
      cnt <= cnt + FILT_W'(1);
    end
  end

  assign fire = (cand != SCS_CODE_OK) && (cand == cand_q)
                && (cnt == FILT_W'(FILTER_CYCLES - 1));

  // Latest filtered fault wins; a new fault beats a clear in the same cycle.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      code <= SCS_CODE_OK;
    end else if (fire) begin
      code <= cand;
    end else if (ch.clear) begin
      code <= SCS_CODE_OK;
    end
  end

  assign ch.code  = code;
  // A hot channel only conducts inside the short chop window.
  assign ch.drive = ch.demand & (~ch.temp | ch.duty);
  assign ch.hot   = ch.temp & ch.on_state;

endmodule // scs_chan_diag

// File: core/scs_top.sv
// Top of the six channel low side switch control and diagnosis core.
// Assumes pin inputs are asynchronous and sclk is the master's clock,
// idle low and still outside frames.
`timescale 1ns/10ps
module scs_top import scs_pkg::*; #(
  parameter int FILTER_CYCLES       = FAULT_FILTER_CYC,
  parameter int THERM_PERIOD_CYCLES = THERM_PERIOD_CYC
) (
  input  wire logic           ref_clk,
  input  wire logic           rst_b,
  input  wire logic           under_voltage,
  input  wire logic           input_polarity_strap,
  input  wire logic [NCH-1:0] parallel_input,
  input  wire logic [NCH-1:0] short_to_battery_sense,
  input  wire logic [NCH-1:0] short_to_ground_sense,
  input  wire logic [NCH-1:0] open_load_sense,
  input  wire logic [NCH-1:0] temp_sense,
  input  wire logic           sclk,
  input  wire logic           cs_b,
  input  wire logic           si,
  output logic                so,
  output logic                so_oe_b,
  output logic [NCH-1:0]      power_output,
  output logic                fault_flag_b
);

  // ****************************************************************
  // Reset
  // ****************************************************************

  // Pin reset and under voltage both reset the whole core.
  logic sys_rst_b;     // Combined asynchronous reset.
  logic rst_meta;      // Release synchroniser, first stage.
  logic ref_rst_b;     // Reset released on ref_clk.

  assign sys_rst_b = rst_b & ~under_voltage;

  // Release the core reset on a clean ref_clk edge.
  always_ff @(posedge ref_clk or negedge sys_rst_b) begin
    if (!sys_rst_b) begin
      rst_meta  <= 1'b0;
      ref_rst_b <= 1'b0;
    end else begin
      rst_meta  <= 1'b1;
      ref_rst_b <= rst_meta;
    end
  end

  // ****************************************************************
  // Serial clock side
  // ****************************************************************

  logic             in_frame;   // A falling edge was seen in this frame.
  logic [CNT_W-1:0] fcnt;       // Falling edges in this frame.
  logic [15:0]      shift_in;   // Received bits, newest at bit 0.
  logic             addr;       // Instruction starts with the tag.
  logic [5:0]       cmd;        // Instruction code of this frame.
  logic             frame_tog;  // Toggles once per started frame.
  logic [CNT_W-1:0] fcnt_eff;   // Edges seen, zero before the first.
  logic [3:0]       tx_idx;     // Bit of the answer to present.
  logic [15:0]      tx_word;    // Answer word.
  logic [7:0]       tx_low;     // Second answer byte.
  logic [13:0]      snap;       // Diagnosis held across the frame.
  logic [NCH-1:0]   scon;       // Serial control bits.
  logic [NCH-1:0]   mux;        // Parallel select bits.

  // A high select ends the frame without needing any sclk edge.
  always_ff @(negedge sclk or posedge cs_b or negedge sys_rst_b) begin
    if (!sys_rst_b) begin
      in_frame <= 1'b0;
    end else if (cs_b) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // Sample input data and count clocks on the falling edge.
  always_ff @(negedge sclk or negedge sys_rst_b) begin
    if (!sys_rst_b) begin
      fcnt      <= '0;
      shift_in  <= 16'h0000;
      addr      <= 1'b0;
      cmd       <= 6'h00;
      frame_tog <= 1'b0;
    end else if (!cs_b) begin
      if (!in_frame) begin
        // First edge of a new frame.
        fcnt      <= CNT_W'(1);
        shift_in  <= {15'h0000, si};
        addr      <= 1'b0;
        cmd       <= 6'h00;
        frame_tog <= ~frame_tog;
      end else begin
        if (fcnt != CNT_W'(FRAME_BITS + 1)) begin
          fcnt <= fcnt + CNT_W'(1);
        end
        shift_in <= {shift_in[14:0], si};
        if (fcnt == CNT_W'(1)) begin
          addr <= ({shift_in[0], si} == ADDR_TAG);
        end
        if (fcnt == CNT_W'(7)) begin
          cmd <= shift_in[6:1];
        end
      end
    end
  end

  // Pick the answer bit for the next rising edge.
  always_comb begin
    fcnt_eff = in_frame ? fcnt : '0;
    if (cmd == CMD_RD_SCON) begin
      tx_low = {scon, READ_PAD};
    end else if (cmd == CMD_RD_MUX) begin
      tx_low = {mux, READ_PAD};
    end else begin
      tx_low = snap[7:0];
    end
    tx_word = {2'b00, snap[13:8], tx_low};
    if (fcnt_eff >= CNT_W'(FRAME_BITS)) begin
      tx_idx = 4'h0;
    end else begin
      tx_idx = 4'(CNT_W'(FRAME_BITS - 1) - fcnt_eff);
    end
  end

  // Shift the answer out on the rising edge, MSB first.
  // The first two bits stay undriven until the tag is known.
  always_ff @(posedge sclk or posedge cs_b or negedge sys_rst_b) begin
    if (!sys_rst_b) begin
      so      <= 1'b0;
      so_oe_b <= 1'b1;
    end else if (cs_b) begin
      so      <= 1'b0;
      so_oe_b <= 1'b1;
    end else begin
      so      <= tx_word[tx_idx] & addr & (fcnt_eff >= CNT_W'(2));
      so_oe_b <= ~(addr && (fcnt_eff >= CNT_W'(2)));
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  localparam int SYNC_W = 5 * NCH + 3;

  logic [SYNC_W-1:0] sync_meta;  // First stage, read only by the second.
  logic [SYNC_W-1:0] sync_q;     // Settled copies.
  logic [NCH-1:0]    par_s;      // Parallel inputs.
  logic [NCH-1:0]    bat_s;      // Battery short senses.
  logic [NCH-1:0]    gnd_s;      // Ground short senses.
  logic [NCH-1:0]    open_s;     // Open load senses.
  logic [NCH-1:0]    temp_s;     // Temperature senses.
  logic              strap_s;    // Polarity strap.
  logic              cs_s;       // Chip select, high when idle.
  logic              tog_s;      // Frame toggle.

  // Two flip-flops before any ref_clk logic reads a parallel, sense or strap pin, the select or the frame toggle.
  always_ff @(posedge ref_clk or negedge ref_rst_b) begin
    if (!ref_rst_b) begin
      // Select resets to its idle high level, so no false frame end follows.
      sync_meta <= SYNC_W'(2);
      sync_q    <= SYNC_W'(2);
    end else begin
      sync_meta <= {parallel_input, short_to_battery_sense,
                    short_to_ground_sense, open_load_sense, temp_sense,
                    input_polarity_strap, cs_b, frame_tog};
      sync_q    <= sync_meta;
    end
  end

  assign {par_s, bat_s, gnd_s, open_s, temp_s, strap_s, cs_s, tog_s} = sync_q;

  // ****************************************************************
  // Frame acceptance
  // ****************************************************************

  logic       cs_q;         // Select one cycle back.
  logic       tog_seen;     // Frame toggle already handled.
  logic       accept;       // Frame ended with exactly sixteen clocks.
  logic [5:0] frame_cmd;    // Instruction of the ended frame.
  logic       diag_clear;   // Diagnosis read completed.

  // The serial side is still once select is high, so its words are stable.
  assign frame_cmd  = shift_in[CMD_MSB:CMD_LSB];
  assign accept     = cs_s && !cs_q && (tog_s != tog_seen)
                      && (fcnt == CNT_W'(FRAME_BITS));
  assign diag_clear = accept && (frame_cmd == CMD_READ_DIAGNOSIS_COMMAND);

  // Note each frame end so a frame without clocks is never taken.
  always_ff @(posedge ref_clk or negedge ref_rst_b) begin
    if (!ref_rst_b) begin
      cs_q     <= 1'b1;
      tog_seen <= 1'b0;
    end else begin
      cs_q <= cs_s;
      if (cs_s && !cs_q) begin
        tog_seen <= tog_s;
      end
    end
  end

  // Serial control bits move in at the end of a good write.
  always_ff @(posedge ref_clk or negedge ref_rst_b) begin
    if (!ref_rst_b) begin
      scon <= SCON_RST;
    end else if (accept && frame_cmd == CMD_WR_SCON) begin
      scon <= shift_in[DATA_MSB:DATA_LSB];
    end
  end

  // Parallel select bits move in at the end of a good write.
  always_ff @(posedge ref_clk or negedge ref_rst_b) begin
    if (!ref_rst_b) begin
      mux <= MUX_RST;
    end else if (accept && frame_cmd == CMD_WR_MUX) begin
      mux <= shift_in[DATA_MSB:DATA_LSB];
    end
  end

  // ****************************************************************
  // Channel control and diagnosis
  // ****************************************************************

  logic [NCH-1:0]     par_act;    // Parallel inputs after polarity.
  logic [NCH-1:0]     demand;     // Channels asked on.
  logic [NCH-1:0]     drive;      // Next output states.
  logic [NCH-1:0]     hot;        // Channels hot while on.
  logic [2*NCH-1:0]   diag;       // Codes, channel six on top.
  logic [THERM_W-1:0] therm_cnt;  // Thermal chop counter.
  logic               duty;       // Chop window open.
  logic               ot;         // Common heat bit.
  logic               fault_any;  // Any fault stored.

  // Strap high keeps inputs as they are, strap low inverts them.
  assign par_act = par_s ^ {NCH{~strap_s}};

  // Serial bit alone in serial mode, ANDed with the pin in parallel mode.
  assign demand = scon & (par_act | ~mux);

  scs_chan_if ch_if [NCH] ();

  // One diagnosis slice per channel.
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign ch_if[i].demand    = demand[i];
    assign ch_if[i].duty      = duty;
    assign ch_if[i].on_state  = power_output[i];
    assign ch_if[i].battery   = bat_s[i];
    assign ch_if[i].ground    = gnd_s[i];
    assign ch_if[i].open_load = open_s[i];
    assign ch_if[i].temp      = temp_s[i];
    assign ch_if[i].clear     = diag_clear;
    assign drive[i]           = ch_if[i].drive;
    assign hot[i]             = ch_if[i].hot;
    assign diag[2*i +: 2]     = ch_if[i].code;

    scs_chan_diag #(
      .FILTER_CYCLES (FILTER_CYCLES)
    ) u_chan (
      .ref_clk (ref_clk),
      .rst_b   (ref_rst_b),
      .ch      (ch_if[i])
    );
  end

  // Free running chop timebase for hot channels.
  always_ff @(posedge ref_clk or negedge ref_rst_b) begin
    if (!ref_rst_b) begin
      therm_cnt <= '0;
      duty      <= 1'b0;
    end else begin
      if (therm_cnt == THERM_W'(THERM_PERIOD_CYCLES - 1)) begin
        therm_cnt <= '0;
      end else begin
        therm_cnt <= therm_cnt + THERM_W'(1);
      end
      duty <= (therm_cnt < THERM_W'(THERM_ON_CYC));
    end
  end

  // Power stages follow the drive, and are off in reset.
  always_ff @(posedge ref_clk or negedge ref_rst_b) begin
    if (!ref_rst_b) begin
      power_output <= '0;
    end else begin
      power_output <= drive;
    end
  end

  // Common heat bit; a new event beats a clear in the same cycle.
  always_ff @(posedge ref_clk or negedge ref_rst_b) begin
    if (!ref_rst_b) begin
      ot <= 1'b0;
    end else if (|hot) begin
      ot <= 1'b1;
    end else if (diag_clear) begin
      ot <= 1'b0;
    end
  end

  assign fault_any = ot || (diag != {NCH{SCS_CODE_OK}});

  // Fault pin is low while any fault is held.
  always_ff @(posedge ref_clk or negedge ref_rst_b) begin
    if (!ref_rst_b) begin
      fault_flag_b <= 1'b1;
    end else begin
      fault_flag_b <= ~fault_any;
    end
  end

  // Diagnosis is frozen while select is low, the answer of this frame.
  always_ff @(posedge ref_clk or negedge ref_rst_b) begin
    if (!ref_rst_b) begin
      snap <= {2'b00, {NCH{SCS_CODE_OK}}};
    end else if (cs_s) begin
      snap <= {fault_any, ot, diag};
    end
  end

endmodule // scs_top

// File: verif/scs_top_props.sv
// Checker watching the top ports of the six channel switch core.
// Assumes it is bound into scs_top and runs on ref_clk.
`timescale 1ns/10ps
module scs_top_props import scs_pkg::*; #(
  parameter int FILTER_CYCLES       = FAULT_FILTER_CYC,
  parameter int THERM_PERIOD_CYCLES = THERM_PERIOD_CYC
) (
  input wire logic           ref_clk,
  input wire logic           rst_b,
  input wire logic           under_voltage,
  input wire logic           input_polarity_strap,
  input wire logic [NCH-1:0] parallel_input,
  input wire logic [NCH-1:0] short_to_battery_sense,
  input wire logic [NCH-1:0] short_to_ground_sense,
  input wire logic [NCH-1:0] open_load_sense,
  input wire logic [NCH-1:0] temp_sense,
  input wire logic           sclk,
  input wire logic           cs_b,
  input wire logic           si,
  input wire logic           so,
  input wire logic           so_oe_b,
  input wire logic [NCH-1:0] power_output,
  input wire logic           fault_flag_b
);
  // ********
  // Helper state
  // ********
  logic [4:0] quiet_cnt; // Cycles of steady pins with select high.
  logic [3:0] since_cs;  // Cycles since select rose, saturating.
  int         run_cnt;   // Consecutive cycles with some short or open load sense active.
  logic       long_seen; // Short or open load senses lasted the full filter time.
  logic       temp_seen; // Heat was reported at some time.

  // Any parallel input, strap, select or supply event restarts the quiet count.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      quiet_cnt <= 5'h00;
    end else if ($changed(parallel_input) || $changed(input_polarity_strap) || !cs_b ||
                 under_voltage) begin
      quiet_cnt <= 5'h00;
    end else if (quiet_cnt != 5'h1f) begin
      quiet_cnt <= quiet_cnt + 5'h01;
    end
  end

  // Keeps the select and sense history.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      since_cs  <= 4'h0;
      run_cnt   <= 0;
      long_seen <= 1'b0;
      temp_seen <= 1'b0;
    end else begin
      since_cs  <= !cs_b ? 4'h0 : (since_cs == 4'hf) ? since_cs : since_cs + 4'h1;
      run_cnt   <= (|(short_to_battery_sense | short_to_ground_sense | open_load_sense)) ?
                   run_cnt + 1 : 0;
      long_seen <= long_seen || (run_cnt >= FILTER_CYCLES);
      temp_seen <= temp_seen || (|temp_sense);
    end
  end

  // ********
  // Properties
  // ********
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_oe_idle;
    cs_b |-> so_oe_b;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("so enabled while deselected");
  property p_so_quiet;
    so_oe_b |-> !so;
  endproperty
  a_so_quiet: assert property (p_so_quiet) else $error("so active while released");
  property p_oe_addr;
    $fell(so_oe_b) |-> !cs_b && sclk;
  endproperty
  a_oe_addr: assert property (p_oe_addr) else $error("so enabled off a rising edge");
  property p_so_edge;
    !cs_b && !$past(cs_b) && $changed(so) |-> sclk;
  endproperty
  a_so_edge: assert property (p_so_edge) else $error("so moved on a falling edge");
  property p_uv_off;
    under_voltage |-> power_output == 6'h00 && fault_flag_b && so_oe_b;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("outputs live in undervoltage");
  property p_fault_filter;
    $fell(fault_flag_b) |-> long_seen || temp_seen;
  endproperty
  a_fault_filter: assert property (p_fault_filter) else $error("fault before filter");
  property p_fault_hold;
    $rose(fault_flag_b) && !under_voltage |-> since_cs inside {[4'h1:4'h8]};
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault cleared alone");
  property p_out_steady;
    quiet_cnt >= 5'h10 && !temp_seen |-> $stable(power_output);
  endproperty
  a_out_steady: assert property (p_out_steady) else $error("output moved alone");

  c_addressed: cover property ($fell(so_oe_b));
  c_fault: cover property ($fell(fault_flag_b));
  c_clear: cover property ($rose(fault_flag_b) && !under_voltage);
endmodule // scs_top_props

bind scs_top scs_top_props #(.FILTER_CYCLES(FILTER_CYCLES),
  .THERM_PERIOD_CYCLES(THERM_PERIOD_CYCLES)) scs_top_props_inst (
  .ref_clk(ref_clk), .rst_b(rst_b), .under_voltage(under_voltage),
  .input_polarity_strap(input_polarity_strap), .parallel_input(parallel_input),
  .short_to_battery_sense(short_to_battery_sense), .short_to_ground_sense(short_to_ground_sense),
  .open_load_sense(open_load_sense), .temp_sense(temp_sense), .sclk(sclk), .cs_b(cs_b),
  .si(si), .so(so), .so_oe_b(so_oe_b), .power_output(power_output), .fault_flag_b(fault_flag_b));

// File: verif/scs_spi_master.sv
// Serial master model standing in for the system microcontroller.
// Assumes the core samples si on falling and shifts so on rising sclk.
`timescale 1ns/10ps
module scs_spi_master (
  output logic     sclk,    // Serial clock, still and low outside frames.
  output logic     cs_b,    // Select, pulled up when idle.
  output logic     si,      // Serial data, pulled up when idle.
  input wire logic so,      // Serial data from the core.
  input wire logic so_oe_b, // Core enable of so, active low.
  output logic     driven   // The core drove so during the last frame.
);
  // Idle levels follow the pull-ups.
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    si = 1'b1;
    driven = 1'b0;
  end

  // Runs one frame of n clocks, MSB first; extra clocks repeat bit 0.
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    driven = 1'b0;
    cs_b = 1'b0;
    #100;
    for (int k = 0; k < n; k++) begin
      sclk = 1'b1;
      si = tx[(k < 16) ? 15 - k : 0];
      #62.5;
      rx = {rx[14:0], so_oe_b ? !so : so};
      driven = driven | !so_oe_b;
      sclk = 1'b0;
      #62.5;
    end
    #150;
    cs_b = 1'b1;
    si = 1'b1;
    #200;
  endtask
endmodule // scs_spi_master

// File: verif/six_channel_switch_diag_spi_test.sv
// Self-checking bench for the six channel switch core.
// Assumes the core package and the serial master model beside it.
`timescale 1ns/10ps
module six_channel_switch_diag_spi_test;
  import scs_pkg::*;
  logic           ref_clk, rst_b, under_voltage, input_polarity_strap; // Core controls.
  logic           sclk, cs_b, si, so, so_oe_b, fault_flag_b, driven;   // Serial and flag.
  logic [NCH-1:0] parallel_input, short_to_battery_sense, short_to_ground_sense; // Pins.
  logic [NCH-1:0] open_load_sense, temp_sense, power_output; // Senses and outputs.
  logic [15:0]    rx;                                         // Last word read back.
  int             n_fail, n_tests, on_cnt, off_cnt;           // Counters.

  scs_top #(.FILTER_CYCLES(8), .THERM_PERIOD_CYCLES(2000)) scs_top_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .under_voltage(under_voltage),
    .input_polarity_strap(input_polarity_strap), .parallel_input(parallel_input),
    .short_to_battery_sense(short_to_battery_sense),
    .short_to_ground_sense(short_to_ground_sense), .open_load_sense(open_load_sense),
    .temp_sense(temp_sense), .sclk(sclk), .cs_b(cs_b), .si(si), .so(so), .so_oe_b(so_oe_b),
    .power_output(power_output), .fault_flag_b(fault_flag_b));
  scs_spi_master scs_spi_master_inst (.sclk(sclk), .cs_b(cs_b), .si(si), .so(so),
    .so_oe_b(so_oe_b), .driven(driven));

  always #2.5 ref_clk = !ref_clk;

  // Compares one value and counts it.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits n edges, then steps just past the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Sends one frame and lets the core take it.
  task automatic frame(input logic [5:0] cmd, input logic [5:0] dat, input int n);
    scs_spi_master_inst.xfer({cmd, 2'h0, dat, 2'h0}, n, rx);
    tick(12);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    #500_000;
    n_fail++;
    $display("[FAIL] %0t ns: run limit reached", $time);
    results();
  end

  // Main sequence.
  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    under_voltage = 1'b0;
    input_polarity_strap = 1'b1;
    {parallel_input, short_to_battery_sense, short_to_ground_sense} = 18'h0_0000;
    {open_load_sense, temp_sense} = 12'h000;
    n_fail = 0;
    n_tests = 0;
    tick(2);
    rst_b = 1'b1;
    tick(4);
    check({8'h00, power_output, fault_flag_b, so_oe_b}, 16'h0003);
    frame(CMD_RD_SCON, 6'h00, 16);
    check({3'h0, rx[12:0]}, 16'h0f03);
    $display("reset test done");
    frame(CMD_WR_MUX, 6'h3f, 16);
    frame(CMD_WR_SCON, 6'h15, 16);
    parallel_input = 6'h3f;
    tick(8);
    check({10'h000, power_output}, 16'h0015);
    frame(CMD_RD_SCON, 6'h00, 16);
    check({8'h00, rx[7:0]}, 16'h0057);
    frame(CMD_RD_MUX, 6'h00, 16);
    check({8'h00, rx[7:0]}, 16'h00ff);
    parallel_input = 6'h05;
    tick(8);
    check({10'h000, power_output}, 16'h0005);
    input_polarity_strap = 1'b0;
    parallel_input = 6'h2a;
    tick(8);
    check({10'h000, power_output}, 16'h0015);
    input_polarity_strap = 1'b1;
    frame(CMD_WR_MUX, 6'h00, 16);
    parallel_input = 6'h00;
    tick(8);
    check({10'h000, power_output}, 16'h0015);
    $display("control test done");
    frame(CMD_WR_SCON, 6'h3f, 15);
    frame(CMD_WR_SCON, 6'h3f, 17);
    check({10'h000, power_output}, 16'h0015);
    frame(6'h06, 6'h3f, 16);
    check({9'h000, driven, power_output}, 16'h0015);
    frame(6'h2f, 6'h3f, 16);
    check({9'h000, driven, power_output}, 16'h0055);
    $display("refusal test done");
    short_to_battery_sense = 6'h01;
    tick(4);
    short_to_battery_sense = 6'h00;
    tick(6);
    check({15'h0000, fault_flag_b}, 16'h0001);
    short_to_battery_sense = 6'h21;
    short_to_ground_sense = 6'h06;
    open_load_sense = 6'h08;
    tick(20);
    open_load_sense = 6'h00;
    short_to_ground_sense = 6'h0a;
    tick(20);
    {short_to_battery_sense, short_to_ground_sense} = 12'h000;
    tick(4);
    check({15'h0000, fault_flag_b}, 16'h0000);
    frame(CMD_WR_SCON, 6'h15, 16);
    check({3'h0, fault_flag_b, rx[11:0]}, 16'h0f31);
    frame(CMD_READ_DIAGNOSIS_COMMAND, 6'h00, 16);
    check({3'h0, fault_flag_b, rx[11:0]}, 16'h1f31);
    frame(CMD_READ_DIAGNOSIS_COMMAND, 6'h00, 16);
    check({4'h0, rx[11:0]}, 16'h0fff);
    $display("fault test done");
    temp_sense = 6'h01;
    on_cnt = 0;
    off_cnt = 0;
    for (int i = 0; i < 4000; i++) begin
      tick(1);
      if (power_output[0]) on_cnt++;
      else off_cnt++;
    end
    check({15'h0000, on_cnt > 1500 && off_cnt > 1500}, 16'h0001);
    temp_sense = 6'h00;
    tick(2);
    frame(CMD_READ_DIAGNOSIS_COMMAND, 6'h00, 16);
    check({15'h0000, rx[12]}, 16'h0001);
    $display("thermal test done");
    short_to_ground_sense = 6'h02;
    tick(20);
    short_to_ground_sense = 6'h00;
    under_voltage = 1'b1;
    tick(1);
    check({8'h00, power_output, fault_flag_b, so_oe_b}, 16'h0003);
    under_voltage = 1'b0;
    tick(4);
    frame(CMD_RD_SCON, 6'h00, 16);
    check({3'h0, rx[12:0]}, 16'h0f03);
    $display("undervoltage test done");
    results();
  end
endmodule // six_channel_switch_diag_spi_test
